// >>> common/ecc_consts.svh
`ifndef ECC_CONSTS_SVH
`define ECC_CONSTS_SVH
// ----------------------------------------
// Register map
// ----------------------------------------
`define ECC_A_FUNC   8'h00
`define ECC_A_FORCE  8'h01
`define ECC_A_MASK7  8'h02
`define ECC_A_DATA7  8'h03
`define ECC_A_DIR    8'h04
`define ECC_A_PORT   8'h05
`define ECC_A_ACT    8'h06
`define ECC_A_NOVW   8'h07
`define ECC_A_SYS    8'h08
`define ECC_A_MCTL   8'h09
`define ECC_A_MOD    8'h0A
`define ECC_A_TCNT   8'h0B
`define ECC_A_FLAGS  8'h0C
`define ECC_A_CAP    8'h10
`define ECC_A_HOLD   8'h18
`define ECC_A_ACC    8'h1C
`define ECC_A_ACCH   8'h20
// ----------------------------------------
// Field positions and values
// ----------------------------------------
`define ECC_MC_FLAT  2
`define ECC_FLAG_MOD 8
`define ECC_RST8     8'h00
`define ECC_RST16    16'h0000
`define ECC_ACC_MAX  8'hFF
`define ECC_ONE16    16'h0001
`endif

// >>> common/ecc_pkg.sv
package ecc_pkg;
	typedef logic [7:0]  ecc_addr_t;
	typedef logic [15:0] ecc_word_t;
	typedef struct packed {
		logic pair16;
		logic saturate;
		logic latch_mode;
	} ecc_sys_t;
	typedef struct packed {
		logic periodic;
		logic enable;
	} ecc_mod_t;
endpackage : ecc_pkg

// >>> hw/ecc_top.sv
// Summary of operation
// - Channels 4-7 hold one capture; channels 0-3 add a holding register.
// - Capture empty after read or latch; holding empty after read.
// - Plain channel overwrites unless no-overwrite set and register full.
// - Latch mode copies capture to holding on zero, zero write, force latch.
// - Latch mode without no-overwrite overwrites capture and holding freely.
// - With no-overwrite in latch mode, capture and holding written only when empty.
// - Queue mode capture shifts capture into holding, then stores new value.
// - Queue mode holding read moves accumulator to its holding and clears.
// - Each buffered channel has an 8-bit edge accumulator plus holding.
// - Saturate bit stops 8-bit accumulators at FF.
// - Accumulator pairs combine into 16-bit counters.
// - Latch events move accumulators to holding and clear them together.
// - Modulus down-counter gives timebase and periodic or single latching.
// - Pins are GPIO until an enabled compare forces them to output.
// - Port writes to owned pins go to a latch driven later.
// - Function select bit 0 means capture, 1 means compare.
// - Force write performs compare action now without setting the flag.
// - Force register always reads zero.
// - Channel-7 mask bit on compare channel forces pin output.
// - Channel 7 compare copies channel-7 data to masked port bits.
// - Mask bit suppresses the pin's own compare action.
// - Simultaneous channel 7 compare wins and drives the data bit.
`timescale 1ns/1ns
`include "ecc_consts.svh"
module ecc_top (
	input  wire logic          CLOCK,
	input  wire logic          NRST,
	input  ecc_pkg::ecc_addr_t ADDR,
	input  ecc_pkg::ecc_word_t WDATA,
	input  wire logic          WR,
	input  wire logic          RD,
	output ecc_pkg::ecc_word_t RDATA,
	input  wire logic [7:0]    PIN_IN,
	output logic [7:0]         PIN_OUT,
	output logic [7:0]         PIN_OE
);
	import ecc_pkg::*;

	function automatic logic sel(input ecc_addr_t a, input ecc_addr_t base,
		input int idx);
		return a == (base + ecc_addr_t'(idx));
	endfunction : sel

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [7:0]  func_sel;
	logic [7:0]  mask7;
	logic [7:0]  data7;
	logic [7:0]  dir;
	logic [7:0]  port_latch;
	logic [7:0]  novw;
	logic [15:0] act_ctrl;
	ecc_sys_t    sys;
	ecc_mod_t    mctl;
	logic [15:0] mod_load;
	logic [15:0] mod_cnt;
	logic [15:0] tcnt;
	logic [8:0]  flags;
	logic [7:0]  oc_line;
	logic [15:0] cmp [8];
	logic [15:0] cap [8];
	logic [7:0]  cap_full;
	logic [15:0] hold [4];
	logic [3:0]  hold_full;
	logic [7:0]  acc [4];
	logic [7:0]  acch [4];
	logic [7:0]  pin_s1;
	logic [7:0]  pin_s2;
	logic [7:0]  pin_d;

	// ----------------------------------------
	// Decode and events
	// ----------------------------------------
	logic [7:0]  rise;
	logic [7:0]  force_bits;
	logic [7:0]  match;
	logic [7:0]  oc_ev;
	logic [7:0]  cap_ev;
	logic [7:0]  rd_cap;
	logic [7:0]  wr_cmp;
	logic [3:0]  rd_hold;
	logic [7:0]  own;
	logic        wr_mod;
	logic        wr_mctl;
	logic        mod_zero;
	logic        latch_ev;
	logic        queue;
	ecc_word_t   rd_word;

	assign rise       = pin_s2 & ~pin_d;
	assign wr_mod     = WR & (ADDR == `ECC_A_MOD);
	assign wr_mctl    = WR & (ADDR == `ECC_A_MCTL);
	assign force_bits = (WR & (ADDR == `ECC_A_FORCE)) ? WDATA[7:0] : `ECC_RST8;
	assign mod_zero   = mctl.enable & (mod_cnt == `ECC_ONE16) & ~wr_mod;
	assign queue      = ~sys.latch_mode;
	assign latch_ev   = sys.latch_mode & (mod_zero
		| (wr_mod & (WDATA == `ECC_RST16))
		| (wr_mctl & WDATA[`ECC_MC_FLAT]));
	assign oc_ev      = func_sel & (match | force_bits);
	assign cap_ev     = ~func_sel & rise;

	genvar n;
	generate
		for (n = 0; n < 8; n++) begin : g_dec
			assign rd_cap[n] = RD & sel(ADDR, `ECC_A_CAP, n);
			assign wr_cmp[n] = WR & sel(ADDR, `ECC_A_CAP, n);
			assign match[n]  = func_sel[n] & (tcnt == cmp[n]);
			assign own[n]    = func_sel[n]
				& ((act_ctrl[2*n+1 -: 2] != 2'h0) | mask7[n]);
		end
		for (n = 0; n < 4; n++) begin : g_hdec
			assign rd_hold[n] = RD & sel(ADDR, `ECC_A_HOLD, n);
		end
	endgenerate

	// ----------------------------------------
	// Pin input synchroniser
	// ----------------------------------------
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			pin_s1 <= `ECC_RST8;
			pin_s2 <= `ECC_RST8;
			pin_d  <= `ECC_RST8;
		end else begin
			pin_s1 <= PIN_IN;
			pin_s2 <= pin_s1;
			pin_d  <= pin_s2;
		end
	end

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			func_sel   <= `ECC_RST8;
			mask7      <= `ECC_RST8;
			data7      <= `ECC_RST8;
			dir        <= `ECC_RST8;
			port_latch <= `ECC_RST8;
			novw       <= `ECC_RST8;
			act_ctrl   <= `ECC_RST16;
			sys        <= '0;
			mctl       <= '0;
		end else if (WR) begin
			if (ADDR == `ECC_A_FUNC) begin
				func_sel <= WDATA[7:0];
			end else if (ADDR == `ECC_A_MASK7) begin
				mask7 <= WDATA[7:0];
			end else if (ADDR == `ECC_A_DATA7) begin
				data7 <= WDATA[7:0];
			end else if (ADDR == `ECC_A_DIR) begin
				dir <= WDATA[7:0];
			end else if (ADDR == `ECC_A_PORT) begin
				port_latch <= WDATA[7:0];
			end else if (ADDR == `ECC_A_ACT) begin
				act_ctrl <= WDATA;
			end else if (ADDR == `ECC_A_NOVW) begin
				novw <= WDATA[7:0];
			end else if (ADDR == `ECC_A_SYS) begin
				sys <= ecc_sys_t'(WDATA[2:0]);
			end else if (ADDR == `ECC_A_MCTL) begin
				mctl <= ecc_mod_t'(WDATA[1:0]);
			end
		end
	end

	// ----------------------------------------
	// Main counter and modulus down-counter
	// ----------------------------------------
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			tcnt <= `ECC_RST16;
		end else begin
			tcnt <= tcnt + `ECC_ONE16;
		end
	end

	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			mod_load <= `ECC_RST16;
			mod_cnt  <= `ECC_RST16;
		end else if (wr_mod) begin
			mod_load <= WDATA;
			mod_cnt  <= WDATA;
		end else if (mod_zero) begin
			mod_cnt <= mctl.periodic ? mod_load : `ECC_RST16;
		end else if (mctl.enable && mod_cnt != `ECC_RST16) begin
			mod_cnt <= mod_cnt - `ECC_ONE16;
		end
	end

	// ----------------------------------------
	// Event flags, write one to clear
	// ----------------------------------------
	logic [8:0] flag_set;
	logic [8:0] flag_clr;
	assign flag_set = {mod_zero, cap_ev | (func_sel & match)};
	assign flag_clr = (WR & (ADDR == `ECC_A_FLAGS)) ? WDATA[8:0] : 9'h000;

	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			flags <= 9'h000;
		end else begin
			flags <= (flags & ~flag_clr) | flag_set;
		end
	end

	// ----------------------------------------
	// Compare values and output actions
	// ----------------------------------------
	generate
		for (n = 0; n < 8; n++) begin : g_oc
			always_ff @(posedge CLOCK or negedge NRST) begin
				if (!NRST) begin
					cmp[n] <= `ECC_RST16;
				end else if (wr_cmp[n]) begin
					cmp[n] <= WDATA;
				end
			end

			always_ff @(posedge CLOCK or negedge NRST) begin
				if (!NRST) begin
					oc_line[n] <= 1'b0;
				end else if (oc_ev[7] && mask7[n]) begin
					oc_line[n] <= data7[n];
				end else if (oc_ev[n] && !mask7[n]) begin
					case (act_ctrl[2*n+1 -: 2])
						2'h1: oc_line[n] <= ~oc_line[n];
						2'h2: oc_line[n] <= 1'b0;
						2'h3: oc_line[n] <= 1'b1;
						default: oc_line[n] <= oc_line[n];
					endcase
				end
			end
		end
	endgenerate

	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			PIN_OUT <= `ECC_RST8;
			PIN_OE  <= `ECC_RST8;
		end else begin
			PIN_OE  <= own | dir;
			PIN_OUT <= (own & oc_line) | (~own & port_latch);
		end
	end

	// ----------------------------------------
	// Capture channels
	// ----------------------------------------
	generate
		for (n = 0; n < 8; n++) begin : g_cap
			if (n >= 4) begin : g_plain
				logic take;
				assign take = cap_ev[n] & (~novw[n] | ~cap_full[n]);

				always_ff @(posedge CLOCK or negedge NRST) begin
					if (!NRST) begin
						cap[n]      <= `ECC_RST16;
						cap_full[n] <= 1'b0;
					end else begin
						if (take) begin
							cap[n] <= tcnt;
						end
						cap_full[n] <= take | (cap_full[n] & ~rd_cap[n]);
					end
				end
			end else begin : g_buf
				logic take;
				logic shift;
				logic lat;
				always_comb begin
					if (sys.latch_mode) begin
						take  = cap_ev[n] & (~novw[n] | ~cap_full[n]);
						shift = 1'b0;
						lat   = latch_ev & (~novw[n] | ~hold_full[n]);
					end else begin
						take  = cap_ev[n]
							& (~novw[n] | ~cap_full[n] | ~hold_full[n]);
						shift = cap_ev[n]
							& (~novw[n] | (cap_full[n] & ~hold_full[n]));
						lat   = 1'b0;
					end
				end

				always_ff @(posedge CLOCK or negedge NRST) begin
					if (!NRST) begin
						cap[n]       <= `ECC_RST16;
						cap_full[n]  <= 1'b0;
						hold[n]      <= `ECC_RST16;
						hold_full[n] <= 1'b0;
					end else begin
						if (take) begin
							cap[n] <= tcnt;
						end
						if (shift || lat) begin
							hold[n] <= cap[n];
						end
						cap_full[n]  <= take
							| (cap_full[n] & ~rd_cap[n] & ~lat);
						hold_full[n] <= shift | lat
							| (hold_full[n] & ~rd_hold[n]);
					end
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Pulse accumulators, paired low/high
	// ----------------------------------------
	generate
		for (n = 0; n < 2; n++) begin : g_acc
			localparam int LO = 2 * n;
			localparam int HI = 2 * n + 1;
			logic clr_lo;
			logic clr_hi;
			logic inc_lo;
			logic inc_hi;
			logic sat8;
			assign sat8   = sys.saturate & ~sys.pair16;
			assign clr_lo = latch_ev | (queue
				& (rd_hold[LO] | (sys.pair16 & rd_hold[HI])));
			assign clr_hi = latch_ev | (queue
				& (rd_hold[HI] | (sys.pair16 & rd_hold[LO])));
			assign inc_lo = rise[LO] & ~(sat8 & (acc[LO] == `ECC_ACC_MAX));
			assign inc_hi = sys.pair16
				? (rise[LO] & (acc[LO] == `ECC_ACC_MAX))
				: (rise[HI] & ~(sat8 & (acc[HI] == `ECC_ACC_MAX)));

			always_ff @(posedge CLOCK or negedge NRST) begin
				if (!NRST) begin
					acc[LO]  <= `ECC_RST8;
					acch[LO] <= `ECC_RST8;
				end else if (clr_lo) begin
					acch[LO] <= acc[LO];
					acc[LO]  <= {7'h00, rise[LO]};
				end else if (inc_lo) begin
					acc[LO] <= acc[LO] + 8'h01;
				end
			end

			always_ff @(posedge CLOCK or negedge NRST) begin
				if (!NRST) begin
					acc[HI]  <= `ECC_RST8;
					acch[HI] <= `ECC_RST8;
				end else if (clr_hi) begin
					acch[HI] <= acc[HI];
					acc[HI]  <= `ECC_RST8;
				end else if (inc_hi) begin
					acc[HI] <= acc[HI] + 8'h01;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	always_comb begin
		rd_word = `ECC_RST16;
		if (ADDR == `ECC_A_FUNC) begin
			rd_word = {8'h00, func_sel};
		end else if (ADDR == `ECC_A_FORCE) begin
			rd_word = `ECC_RST16;
		end else if (ADDR == `ECC_A_MASK7) begin
			rd_word = {8'h00, mask7};
		end else if (ADDR == `ECC_A_DATA7) begin
			rd_word = {8'h00, data7};
		end else if (ADDR == `ECC_A_DIR) begin
			rd_word = {8'h00, dir};
		end else if (ADDR == `ECC_A_PORT) begin
			rd_word = {8'h00, pin_s2};
		end else if (ADDR == `ECC_A_ACT) begin
			rd_word = act_ctrl;
		end else if (ADDR == `ECC_A_NOVW) begin
			rd_word = {8'h00, novw};
		end else if (ADDR == `ECC_A_SYS) begin
			rd_word = {13'h0000, sys};
		end else if (ADDR == `ECC_A_MCTL) begin
			rd_word = {14'h0000, mctl};
		end else if (ADDR == `ECC_A_MOD) begin
			rd_word = mod_cnt;
		end else if (ADDR == `ECC_A_TCNT) begin
			rd_word = tcnt;
		end else if (ADDR == `ECC_A_FLAGS) begin
			rd_word = {7'h00, flags};
		end
		for (int i = 0; i < 8; i++) begin
			if (sel(ADDR, `ECC_A_CAP, i)) begin
				rd_word = func_sel[i] ? cmp[i] : cap[i];
			end
		end
		for (int i = 0; i < 4; i++) begin
			if (sel(ADDR, `ECC_A_HOLD, i)) begin
				rd_word = hold[i];
			end else if (sel(ADDR, `ECC_A_ACC, i)) begin
				rd_word = {8'h00, acc[i]};
			end else if (sel(ADDR, `ECC_A_ACCH, i)) begin
				rd_word = {8'h00, acch[i]};
			end
		end
	end

	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			RDATA <= `ECC_RST16;
		end else begin
			RDATA <= RD ? rd_word : `ECC_RST16;
		end
	end
endmodule : ecc_top

// >>> verif/ecc_pin_model.sv
`timescale 1ns/1ns
module ecc_pin_model (
	input  wire logic  clock,
	output logic [7:0] pin_ext
);
	initial pin_ext = 8'h00;
	// Rising edge on masked pins, seven clocks per call
	task automatic pulse(input logic [7:0] m);
		@(posedge clock);
		pin_ext <= pin_ext | m;
		repeat (3) @(posedge clock);
		pin_ext <= pin_ext & ~m;
		repeat (3) @(posedge clock);
	endtask : pulse
endmodule : ecc_pin_model

// >>> verif/ecc_top_assertions.sv
`timescale 1ns/1ns
`include "ecc_consts.svh"
module ecc_top_assertions (
	input wire logic          CLOCK,
	input wire logic          NRST,
	input ecc_pkg::ecc_addr_t ADDR,
	input ecc_pkg::ecc_word_t WDATA,
	input wire logic          WR,
	input wire logic          RD,
	input ecc_pkg::ecc_word_t RDATA,
	input wire logic [7:0]    PIN_IN,
	input wire logic [7:0]    PIN_OUT,
	input wire logic [7:0]    PIN_OE
);
	import ecc_pkg::*;
	logic [7:0]  func, mask, dat7, dir, port, own, act_nz;
	logic [15:0] act;
	// ----------------------------------------
	// Register shadows
	// ----------------------------------------
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			func <= 8'h00;
			mask <= 8'h00;
			dat7 <= 8'h00;
			dir  <= 8'h00;
			port <= 8'h00;
			act  <= 16'h0000;
		end else if (WR) begin
			case (ADDR)
				`ECC_A_FUNC:  func <= WDATA[7:0];
				`ECC_A_MASK7: mask <= WDATA[7:0];
				`ECC_A_DATA7: dat7 <= WDATA[7:0];
				`ECC_A_DIR:   dir  <= WDATA[7:0];
				`ECC_A_PORT:  port <= WDATA[7:0];
				`ECC_A_ACT:   act  <= WDATA;
				default: ;
			endcase
		end
	end
	always_comb begin
		for (int n = 0; n < 8; n++) begin
			act_nz[n] = |act[2*n +: 2];
		end
		own = func & (act_nz | mask);
	end
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!NRST);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	AST_RDATA_IDLE: assert property (!$past(RD) |-> RDATA == 16'h0000)
		else $error("read data not zero outside read answer");
	AST_FORCE_READ: assert property ($past(RD) &&
		$past(ADDR) == `ECC_A_FORCE |-> RDATA == 16'h0000)
		else $error("force register read not zero");
	AST_FUNC_READ: assert property ($past(RD) &&
		$past(ADDR) == `ECC_A_FUNC |-> RDATA == {8'h00, $past(func)})
		else $error("function select read back wrong");
	AST_MASK_READ: assert property ($past(RD) &&
		$past(ADDR) == `ECC_A_MASK7 |-> RDATA == {8'h00, $past(mask)})
		else $error("channel 7 mask read back wrong");
	AST_PIN_OE: assert property (PIN_OE == $past(dir | own))
		else $error("pin enable not direction or ownership");
	AST_PORT_LATCH: assert property (
		((PIN_OUT ^ $past(port)) & $past(dir & ~own)) == 8'h00)
		else $error("general output pin not driven from latch");
	AST_FORCE7: assert property (WR && ADDR == `ECC_A_FORCE &&
		WDATA[7] && func[7] |->
		##[1:3] (((PIN_OUT ^ dat7) & mask & func) == 8'h00))
		else $error("forced channel 7 did not drive masked pins");
	AST_TCNT_STEP: assert property ($past(RD, 2) &&
		$past(ADDR, 2) == `ECC_A_TCNT && $past(RD) &&
		$past(ADDR) == `ECC_A_TCNT |-> RDATA == $past(RDATA) + 16'h0001)
		else $error("counter reads not one apart");
endmodule : ecc_top_assertions
bind ecc_top ecc_top_assertions i_ecc_top_assertions (.CLOCK(CLOCK),
	.NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
	.RDATA(RDATA), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE));

// >>> verif/ecc_top_tb.sv
`timescale 1ns/1ns
`include "ecc_consts.svh"
module ecc_top_tb;
	import ecc_pkg::*;
	logic       CLOCK, NRST, WR, RD;
	ecc_addr_t  ADDR;
	ecc_word_t  WDATA, RDATA, v, w;
	logic [7:0] PIN_IN, PIN_OUT, PIN_OE, pin_ext;
	int         errors, samples_checked;
	ecc_top i_ecc_top (.CLOCK(CLOCK), .NRST(NRST), .ADDR(ADDR),
		.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .PIN_IN(PIN_IN),
		.PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE));
	ecc_pin_model i_ecc_pin_model (.clock(CLOCK), .pin_ext(pin_ext));
	assign PIN_IN = (PIN_OE & PIN_OUT) | (~PIN_OE & pin_ext);
	always #50 CLOCK = ~CLOCK;
	// ----------------------------------------
	// Bus and check helpers
	// ----------------------------------------
	task automatic chk(input ecc_word_t got, input ecc_word_t exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input ecc_addr_t a, input ecc_word_t d);
		@(posedge CLOCK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'h1;
		@(posedge CLOCK);
		WR <= 1'h0;
	endtask : wr
	task automatic rd(input ecc_addr_t a, output ecc_word_t d);
		@(posedge CLOCK);
		ADDR <= a;
		RD <= 1'h1;
		@(posedge CLOCK);
		RD <= 1'h0;
		#1;
		d = RDATA;
	endtask : rd
	task automatic summarize;
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : summarize
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_regs;
		wr(`ECC_A_FUNC, 16'h00A5);
		rd(`ECC_A_FUNC, v);
		chk(v, 16'h00A5);
		wr(`ECC_A_FORCE, 16'h00FF);
		rd(`ECC_A_FORCE, v);
		chk(v, 16'h0000);
		rd(8'hFF, v);
		chk(v, 16'h0000);
		wr(`ECC_A_FUNC, 16'h0000);
		wr(`ECC_A_ACT, 16'hFFFF);
		rd(`ECC_A_ACT, v);
		chk(v, 16'hFFFF);
		wr(`ECC_A_ACT, 16'h0000);
		@(posedge CLOCK);
		ADDR <= `ECC_A_TCNT;
		RD <= 1'h1;
		@(posedge CLOCK);
		#1;
		v = RDATA;
		@(posedge CLOCK);
		RD <= 1'h0;
		#1;
		chk(RDATA - v, 16'h0001);
		i_ecc_pin_model.pulse(8'h28);
		rd(`ECC_A_ACC + 8'h03, v);
		chk(v, 16'h0001);
		$display("test regs done");
	endtask : t_regs
	task automatic t_queue;
		wr(`ECC_A_NOVW, 16'h0010);
		i_ecc_pin_model.pulse(8'h11);
		repeat (40) @(posedge CLOCK);
		i_ecc_pin_model.pulse(8'h11);
		rd(`ECC_A_HOLD, w);
		rd(`ECC_A_CAP, v);
		chk(v - w, 16'h002F);
		rd(`ECC_A_CAP + 8'h04, v);
		chk(v, w);
		rd(`ECC_A_ACCH, v);
		chk(v, 16'h0002);
		rd(`ECC_A_ACC, v);
		chk(v, 16'h0000);
		wr(`ECC_A_NOVW, 16'h0000);
		i_ecc_pin_model.pulse(8'h11);
		i_ecc_pin_model.pulse(8'h11);
		rd(`ECC_A_CAP, w);
		rd(`ECC_A_CAP + 8'h04, v);
		chk(v, w);
		$display("test queue done");
	endtask : t_queue
	task automatic t_latch;
		wr(`ECC_A_SYS, 16'h0001);
		i_ecc_pin_model.pulse(8'h02);
		i_ecc_pin_model.pulse(8'h02);
		wr(`ECC_A_MCTL, 16'h0001);
		wr(`ECC_A_MOD, 16'h0005);
		repeat (12) @(posedge CLOCK);
		rd(`ECC_A_ACCH + 8'h01, v);
		chk(v, 16'h0002);
		rd(`ECC_A_ACC + 8'h01, v);
		chk(v, 16'h0000);
		i_ecc_pin_model.pulse(8'h01);
		rd(`ECC_A_CAP, v);
		wr(`ECC_A_MCTL, 16'h0004);
		rd(`ECC_A_HOLD, w);
		chk(w, v);
		i_ecc_pin_model.pulse(8'h01);
		rd(`ECC_A_CAP, v);
		wr(`ECC_A_MOD, 16'h0000);
		rd(`ECC_A_HOLD, w);
		chk(w, v);
		$display("test latch done");
	endtask : t_latch
	task automatic t_accum;
		wr(`ECC_A_SYS, 16'h0002);
		for (int i = 0; i < 260; i++) i_ecc_pin_model.pulse(8'h02);
		rd(`ECC_A_ACC + 8'h01, v);
		chk(v, 16'h00FF);
		wr(`ECC_A_SYS, 16'h0006);
		for (int i = 0; i < 260; i++) i_ecc_pin_model.pulse(8'h04);
		rd(`ECC_A_ACC + 8'h02, v);
		chk(v, 16'h0004);
		rd(`ECC_A_ACC + 8'h03, v);
		chk(v, 16'h0001);
		$display("test accum done");
	endtask : t_accum
	task automatic t_compare;
		wr(`ECC_A_FLAGS, 16'h01FF);
		wr(`ECC_A_FUNC, 16'h00C1);
		wr(`ECC_A_ACT, 16'h3002);
		wr(`ECC_A_MASK7, 16'h0081);
		wr(`ECC_A_DATA7, 16'h0081);
		wr(`ECC_A_PORT, 16'h0000);
		wr(`ECC_A_FORCE, 16'h0081);
		repeat (3) @(posedge CLOCK);
		chk({8'h00, PIN_OUT & 8'h81}, 16'h0081);
		chk({8'h00, PIN_OE & 8'hC1}, 16'h00C1);
		rd(`ECC_A_MASK7, v);
		chk(v, 16'h0081);
		rd(`ECC_A_FLAGS, v);
		chk(v & 16'h0081, 16'h0000);
		rd(`ECC_A_TCNT, v);
		wr(`ECC_A_CAP + 8'h06, v + 16'h0028);
		repeat (60) @(posedge CLOCK);
		chk({15'h0000, PIN_OUT[6]}, 16'h0001);
		rd(`ECC_A_FLAGS, v);
		chk(v & 16'h0040, 16'h0040);
		wr(`ECC_A_DIR, 16'h0001);
		wr(`ECC_A_MASK7, 16'h0000);
		wr(`ECC_A_PORT, 16'h0001);
		wr(`ECC_A_FORCE, 16'h0001);
		repeat (3) @(posedge CLOCK);
		chk({14'h0000, PIN_OE[0], PIN_OUT[0]}, 16'h0002);
		wr(`ECC_A_FUNC, 16'h0000);
		repeat (3) @(posedge CLOCK);
		chk({14'h0000, PIN_OE[0], PIN_OUT[0]}, 16'h0003);
		$display("test compare done");
	endtask : t_compare
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		CLOCK = 1'h0;
		NRST = 1'h0;
		WR = 1'h0;
		RD = 1'h0;
		ADDR = 8'h00;
		WDATA = 16'h0000;
		errors = 0;
		samples_checked = 0;
		repeat (2) @(posedge CLOCK);
		NRST <= 1'h1;
		t_regs;
		t_queue;
		t_latch;
		t_accum;
		t_compare;
		summarize;
	end
	initial begin
		repeat (100000) @(posedge CLOCK);
		errors++;
		summarize;
	end
endmodule : ecc_top_tb
